// >>> rdtm_monitor.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module rdtm_monitor import rdtm_pkg::*; (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [5:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             conv_start_out,
  output logic             conv_chan_out,
  input  wire logic        conv_done_in,
  input  wire logic [7:0]  conv_data_in,
  input  wire logic [1:0]  diode_open_in,
  input  wire logic [1:0]  diode_short_in,
  output logic             alert_out,
  output logic             overtemp_shutdown_out,
  output logic             mgmt_interrupt_out,
  output logic             irq_out
);
  logic [7:0]   evt_reg;
  logic [7:0]   mgmt_reg;
  logic [7:0]   irq_reg;
  logic [7:0]   gcfg_reg;
  logic [3:0]   bank_reg;
  logic [31:0]  prdata_reg;
  logic         pready_reg;
  logic [3:0]   fault_s1_reg;
  logic [3:0]   fault_s2_reg;
  rdtm_seq_type state_reg;
  logic         ch_reg;
  logic [7:0]   gap_reg;
  logic         open_reg;
  logic         short_reg;
  logic         start_reg;
  logic         chan_reg;
  logic         alert_reg;
  logic         ots_reg;
  logic         mgmt_out_reg;
  logic         irq_out_reg;

  logic         setup_w;
  logic         wr_w;
  logic [3:0]   idx_w;
  logic [7:0]   wd_w;
  logic         bank_ok_w;
  logic         bank_ch_w;
  logic         done_w;
  logic         ch_en_w;
  logic [7:0]   res_w;
  logic         hix_w;
  logic         lox_w;
  logic         otx_w;
  logic [7:0]   evt_next;
  logic [7:0]   ch_data_w;
  logic [7:0]   rdata_w;
  logic [NUM_CH-1:0] alert_ch_w;
  logic [NUM_CH-1:0] ots_ch_w;
  logic [7:0]   ccs_w [NUM_CH];
  logic [7:0]   rd_w  [NUM_CH];
  logic [7:0]   hi_w  [NUM_CH];
  logic [7:0]   lo_w  [NUM_CH];
  logic [7:0]   ot_w  [NUM_CH];

  // APB decode: one wait-free access phase, writes land on its edge.
  assign setup_w   = psel_in & ~penable_in;
  assign wr_w      = psel_in & penable_in & pready_reg & pwrite_in;
  assign idx_w     = paddr_in[5:2];
  assign wd_w      = pwdata_in[7:0];
  // Bank values other than the two channels map no channel registers.
  assign bank_ok_w = (bank_reg[3:1] == 3'h0);
  assign bank_ch_w = bank_reg[0];

  // Conversion result, substituted by the fault check outcome.
  assign done_w  = (state_reg == SEQ_CONV) & conv_done_in;
  assign ch_en_w = ccs_w[ch_reg][CCS_EN];
  assign res_w   = open_reg  ? TEMP_OPEN  :
                   short_reg ? TEMP_SHORT :
                   conv_data_in;

  // One comparator serves both channels since they convert in turn.
  rdtm_limit_cmp u_cmp (
    .temp_in    (res_w),
    .high_in    (hi_w[ch_reg]),
    .low_in     (lo_w[ch_reg]),
    .ot_in      (ot_w[ch_reg]),
    .short_in   (short_reg),
    .high_x_out (hix_w),
    .low_x_out  (lox_w),
    .ot_x_out   (otx_w)
  );

  // Banked per-channel register copies.
  for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
    logic [7:0] ccs_reg;
    logic [7:0] rd_reg;
    logic [7:0] hi_reg;
    logic [7:0] lo_reg;
    logic [7:0] ot_reg;
    logic       sel_w;
    logic       upd_w;
    logic       ccs_wr_w;
    logic [7:0] set_w;
    logic [7:0] clr_w;
    logic [7:0] base_w;
    logic       open_w;

    assign sel_w    = wr_w & bank_ok_w & (bank_ch_w == 1'(g));
    assign ccs_wr_w = sel_w & (idx_w == IDX_CCS);
    assign upd_w    = done_w & (ch_reg == 1'(g));
    assign set_w    = upd_w ? (M_EOC | ({8{open_reg}} & M_OPEN) |
                      ({8{otx_w}} & M_OTX) | ({8{hix_w}} & M_HIX) |
                      ({8{lox_w}} & M_LOX)) : 8'h00;
    assign clr_w    = ccs_wr_w ? (wd_w & CCS_W1C) : 8'h00;
    assign base_w   = ccs_wr_w ? ((ccs_reg & ~CCS_RW) | (wd_w & CCS_RW))
                               : ccs_reg;
    assign open_w   = ccs_reg[CCS_OPEN];

    // A hardware set in the clearing cycle wins over the clear.
    always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
        ccs_reg <= CCS_RST;
        rd_reg  <= RD_RST;
        hi_reg  <= HI_RST;
        lo_reg  <= LO_RST;
        ot_reg  <= OT_RST;
      end else begin
        ccs_reg <= (base_w & ~clr_w) | set_w;
        if (upd_w) begin
          rd_reg <= res_w;
        end
        if (sel_w && idx_w == IDX_HI) begin
          hi_reg <= wd_w;
        end
        if (sel_w && idx_w == IDX_LO) begin
          lo_reg <= wd_w;
        end
        if (sel_w && idx_w == IDX_OT) begin
          ot_reg <= wd_w;
        end
      end
    end

    // Event causes; an open diode raises both alert and overtemperature.
    assign evt_next[EVT_STEP*g+EVT_ALERT] = ccs_reg[CCS_HIX] |
                       ccs_reg[CCS_LOX] | open_w;
    assign evt_next[EVT_STEP*g+EVT_OT]    = ccs_reg[CCS_OTX] | open_w;
    assign alert_ch_w[g] = ccs_reg[CCS_ALEN] & (ccs_reg[CCS_HIX] |
                           ccs_reg[CCS_LOX] | open_w);
    assign ots_ch_w[g]   = ccs_reg[CCS_OTSEN] & (ccs_reg[CCS_OTX] | open_w);
    assign ccs_w[g] = ccs_reg;
    assign rd_w[g]  = rd_reg;
    assign hi_w[g]  = hi_reg;
    assign lo_w[g]  = lo_reg;
    assign ot_w[g]  = ot_reg;
  end
  assign evt_next[7:4] = 4'h0;

  // Read selection; unmapped offsets and banks read zero.
  assign ch_data_w = (idx_w == IDX_CCS) ? ccs_w[bank_ch_w] :
                     (idx_w == IDX_RD)  ? rd_w[bank_ch_w]  :
                     (idx_w == IDX_HI)  ? hi_w[bank_ch_w]  :
                     (idx_w == IDX_LO)  ? lo_w[bank_ch_w]  :
                     (idx_w == IDX_OT)  ? ot_w[bank_ch_w]  : 8'h00;
  assign rdata_w   = (idx_w == IDX_EVT)  ? evt_reg  :
                     (idx_w == IDX_MGMT) ? mgmt_reg :
                     (idx_w == IDX_IRQ)  ? irq_reg  :
                     (idx_w == IDX_GCFG) ? gcfg_reg :
                     (idx_w == IDX_BANK) ? {4'h0, bank_reg} :
                     bank_ok_w ? ch_data_w : 8'h00;

  // Bus answer: ready and read data are both captured at setup.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pready_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= setup_w;
      if (setup_w) begin
        prdata_reg <= {24'h000000, rdata_w};
      end
    end
  end

  // Global registers; writes mask off reserved bits.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      evt_reg  <= EVT_RST;
      mgmt_reg <= ROUTE_RST;
      irq_reg  <= ROUTE_RST;
      gcfg_reg <= GCFG_RST;
      bank_reg <= BANK_RST;
    end else begin
      // Status only falls once software has cleared every cause.
      evt_reg <= evt_next;
      if (wr_w && idx_w == IDX_MGMT) begin
        mgmt_reg <= wd_w & EVT_MASK;
      end
      if (wr_w && idx_w == IDX_IRQ) begin
        irq_reg <= wd_w & EVT_MASK;
      end
      if (wr_w && idx_w == IDX_GCFG) begin
        gcfg_reg <= wd_w & GCFG_MASK;
      end
      if (wr_w && idx_w == IDX_BANK) begin
        bank_reg <= wd_w[3:0];
      end
    end
  end

  // Diode fault levels come from analog comparators, so synchronise them.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      fault_s1_reg <= 4'h0;
      fault_s2_reg <= 4'h0;
    end else begin
      fault_s1_reg <= {diode_short_in, diode_open_in};
      fault_s2_reg <= fault_s1_reg;
    end
  end

  // Conversion sequencer; a started conversion finishes even if standby
  // is requested meanwhile, so a reading is never half updated.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state_reg <= SEQ_IDLE;
      ch_reg    <= 1'b0;
      gap_reg   <= GAP_LOAD;
      open_reg  <= 1'b0;
      short_reg <= 1'b0;
      start_reg <= 1'b0;
      chan_reg  <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      unique case (state_reg)
        SEQ_IDLE: begin
          if (gap_reg != '0) begin
            gap_reg <= gap_reg - 8'h01;
          end else if (!gcfg_reg[GCFG_STBY]) begin
            if (ch_en_w) begin
              state_reg <= SEQ_CHECK;
            end else begin
              ch_reg  <= ~ch_reg;
              gap_reg <= GAP_LOAD;
            end
          end
        end
        SEQ_CHECK: begin
          open_reg  <= fault_s2_reg[ch_reg];
          short_reg <= fault_s2_reg[NUM_CH + 32'(ch_reg)];
          start_reg <= 1'b1;
          chan_reg  <= ch_reg;
          state_reg <= SEQ_CONV;
        end
        SEQ_CONV: begin
          if (conv_done_in) begin
            state_reg <= SEQ_IDLE;
            ch_reg    <= ~ch_reg;
            gap_reg   <= GAP_LOAD;
          end
        end
      endcase
    end
  end

  // Output pins, all registered.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      alert_reg    <= 1'b0;
      ots_reg      <= 1'b0;
      mgmt_out_reg <= 1'b0;
      irq_out_reg  <= 1'b0;
    end else begin
      alert_reg    <= |alert_ch_w;
      ots_reg      <= |ots_ch_w;
      mgmt_out_reg <= |(evt_reg & mgmt_reg);
      irq_out_reg  <= |(evt_reg & irq_reg);
    end
  end

  assign prdata_out            = prdata_reg;
  assign pready_out            = pready_reg;
  assign conv_start_out        = start_reg;
  assign conv_chan_out         = chan_reg;
  assign alert_out             = alert_reg;
  assign overtemp_shutdown_out = ots_reg;
  assign mgmt_interrupt_out    = mgmt_out_reg;
  assign irq_out               = irq_out_reg;

  // Checks on the sequencer, status and routing.
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  logic ccs0_wr_w;
  assign ccs0_wr_w = wr_w & bank_ok_w & ~bank_ch_w & (idx_w == IDX_CCS);

  reading_load_a: assert property (
    done_w && !open_reg && !short_reg && !ch_reg
    |=> rd_w[0] == $past(conv_data_in))
    else $error("reading not loaded from conversion");
  open_fault_a: assert property (
    done_w && open_reg && !ch_reg
    |=> rd_w[0] == TEMP_OPEN && ccs_w[0][CCS_OPEN])
    else $error("open diode not reported");
  short_fault_a: assert property (
    done_w && short_reg && !open_reg && !ch_reg && !$past(ccs_w[0][CCS_LOX])
    |=> rd_w[0] == TEMP_SHORT ##0 !ccs_w[0][CCS_LOX])
    else $error("shorted diode set low flag");
  standby_hold_a: assert property (
    gcfg_reg[GCFG_STBY] && state_reg == SEQ_IDLE |=> state_reg == SEQ_IDLE)
    else $error("conversion started in standby");
  check_first_a: assert property (
    conv_start_out |-> $past(state_reg) == SEQ_CHECK)
    else $error("conversion without fault check");
  w1c_clear_a: assert property (
    ccs0_wr_w && wd_w[CCS_HIX] && !done_w |=> !ccs_w[0][CCS_HIX])
    else $error("written one did not clear");
  w1c_keep_a: assert property (
    ccs0_wr_w && !wd_w[CCS_HIX] && ccs_w[0][CCS_HIX] |=> ccs_w[0][CCS_HIX])
    else $error("written zero cleared a bit");
  event_sticky_a: assert property (
    $fell(evt_reg[EVT_ALERT]) |-> $past(wr_w, 2))
    else $error("event status fell without software");
  event_reserved_a: assert property (
    evt_reg[7:4] == 4'h0)
    else $error("reserved event bits set");
  mgmt_route_a: assert property (
    |(evt_reg & mgmt_reg) |=> mgmt_interrupt_out)
    else $error("management interrupt missing");
  irq_route_a: assert property (
    ##1 irq_out == $past(|(evt_reg & irq_reg)))
    else $error("interrupt does not follow status");
  reset_vals_a: assert property (
    $rose(rstn_in) |-> hi_w[0] == HI_RST && lo_w[1] == LO_RST &&
    ot_w[1] == OT_RST && bank_reg == BANK_RST)
    else $error("wrong power-up values");

  conv_done_c: cover property (done_w);
  open_seen_c: cover property (done_w && open_reg);
  mgmt_irq_c:  cover property ($rose(mgmt_interrupt_out));
  w1c_write_c: cover property (ccs0_wr_w && wd_w[CCS_HIX]);
endmodule : rdtm_monitor

// >>> rdtm_pkg.sv
// Function
// - Readings and limits are 8-bit two's complement, one degree per count.
// - Each channel reading holds the result of its latest finished conversion.
// - Event status bits persist until software clears their causes.
// - Remote readings show zero after power-on until a diode is measured.
// - Power-up limits: overtemperature and high 127 degrees, low minus 55.
// - Standby bit set, its default, starts no new conversion; one already started finishes.
// - In standby registers keep contents and stay readable and writable.
// - A diode fault check precedes every conversion of a channel.
// - Open or supply-shorted diode reads 127, sets open bit, drives outputs.
// - Diode shorted low reads zero and never sets the low-limit bit.
// - Per-channel registers 0x0a to 0x0e are banked, one copy per channel.
// - Write-one-to-clear bits clear on a written 1, keep on 0.
// - Event status is read-only: bits 3..0 events, bits 7..4 reserved.
// - Event status resets to all zeros.
// - Management routing register: one enable per event, reset disabled.
// - Management interrupt is active when any enabled event status is set.
// - Normal interrupt is active when any enabled event status is set.
// - Limit-exceeded channel bits set matching alert or overtemp event bits.
// - Bank 0 selects channel 1 after reset, bank 1 selects channel 2.
package rdtm_pkg;
  localparam int NUM_CH         = 2;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CONV_GAP_NS    = 1000;
  localparam int CONV_GAP_CYC   = (CONV_GAP_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  CONV_GAP_NS / CLK_PERIOD_NS;
  localparam logic [7:0] GAP_LOAD = 8'(CONV_GAP_CYC - 1);

  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_EVT  = 4'h0;
  localparam logic [3:0] IDX_MGMT = 4'h2;
  localparam logic [3:0] IDX_IRQ  = 4'h4;
  localparam logic [3:0] IDX_GCFG = 4'h8;
  localparam logic [3:0] IDX_BANK = 4'h9;
  localparam logic [3:0] IDX_CCS  = 4'ha;
  localparam logic [3:0] IDX_RD   = 4'hb;
  localparam logic [3:0] IDX_HI   = 4'hc;
  localparam logic [3:0] IDX_LO   = 4'hd;
  localparam logic [3:0] IDX_OT   = 4'he;

  // Reset values and fixed readings.
  localparam logic [7:0] EVT_RST    = 8'h00;
  localparam logic [7:0] ROUTE_RST  = 8'h00;
  localparam logic [7:0] GCFG_RST   = 8'h03;
  localparam logic [3:0] BANK_RST   = 4'h0;
  localparam logic [7:0] CCS_RST    = 8'h00;
  localparam logic [7:0] RD_RST     = 8'h00;
  localparam logic [7:0] HI_RST     = 8'h7f;
  localparam logic [7:0] LO_RST     = 8'hc9;
  localparam logic [7:0] OT_RST     = 8'h7f;
  localparam logic [7:0] TEMP_OPEN  = 8'h7f;
  localparam logic [7:0] TEMP_SHORT = 8'h00;

  // Field layouts.
  localparam logic [7:0] EVT_MASK  = 8'h0f;
  localparam logic [7:0] GCFG_MASK = 8'h03;
  localparam int         GCFG_STBY = 0;
  localparam int         EVT_ALERT = 0;
  localparam int         EVT_OT    = 1;
  localparam int         EVT_STEP  = 2;
  localparam int         CCS_OPEN  = 6;
  localparam int         CCS_OTSEN = 5;
  localparam int         CCS_ALEN  = 4;
  localparam int         CCS_OTX   = 3;
  localparam int         CCS_HIX   = 2;
  localparam int         CCS_LOX   = 1;
  localparam int         CCS_EN    = 0;
  localparam logic [7:0] M_EOC     = 8'h80;
  localparam logic [7:0] M_OPEN    = 8'h40;
  localparam logic [7:0] M_OTX     = 8'h08;
  localparam logic [7:0] M_HIX     = 8'h04;
  localparam logic [7:0] M_LOX     = 8'h02;
  localparam logic [7:0] CCS_W1C   = 8'hce;
  localparam logic [7:0] CCS_RW    = 8'h31;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CHECK, SEQ_CONV} rdtm_seq_type;
endpackage : rdtm_pkg

// >>> rdtm_limit_cmp.sv
`timescale 1ns/1ps
// Signed limit comparison of one finished conversion result.
module rdtm_limit_cmp import rdtm_pkg::*; (
  input  wire logic [7:0] temp_in,
  input  wire logic [7:0] high_in,
  input  wire logic [7:0] low_in,
  input  wire logic [7:0] ot_in,
  input  wire logic       short_in,
  output logic            high_x_out,
  output logic            low_x_out,
  output logic            ot_x_out
);
  // All values are two's complement degrees, so compare signed.
  assign high_x_out = $signed(temp_in) > $signed(high_in);
  assign ot_x_out   = $signed(temp_in) > $signed(ot_in);
  // A shorted diode forces zero that must not look like a cold reading.
  assign low_x_out  = ~short_in &
                      ($signed(temp_in) < $signed(low_in));
endmodule : rdtm_limit_cmp

// >>> remote_diode_temp_monitor_tb_top.sv
`timescale 1ns/1ps
module remote_diode_temp_monitor_tb_top;
  import rdtm_pkg::*;

  typedef struct packed {
    logic       wr;
    logic [3:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } rdtm_row_type;

  // Reset rows first (read only), then write and read-back rows with one plain read-back row.
  localparam rdtm_row_type ROWS [27] = '{
    '{1'b0, 4'h0, 8'h00, 8'h00}, '{1'b0, 4'h1, 8'h00, 8'h00},
    '{1'b0, 4'h2, 8'h00, 8'h00}, '{1'b0, 4'h4, 8'h00, 8'h00},
    '{1'b0, 4'h8, 8'h00, 8'h03}, '{1'b0, 4'h9, 8'h00, 8'h00},
    '{1'b0, 4'ha, 8'h00, 8'h00}, '{1'b0, 4'hb, 8'h00, 8'h00},
    '{1'b0, 4'hc, 8'h00, 8'h7f}, '{1'b0, 4'hd, 8'h00, 8'hc9},
    '{1'b0, 4'he, 8'h00, 8'h7f}, '{1'b0, 4'hf, 8'h00, 8'h00},
    '{1'b1, 4'h2, 8'hff, 8'h0f}, '{1'b1, 4'h4, 8'hff, 8'h0f},
    '{1'b1, 4'h0, 8'hff, 8'h00}, '{1'b1, 4'h1, 8'hff, 8'h00},
    '{1'b1, 4'h8, 8'hfd, 8'h01}, '{1'b1, 4'h9, 8'hf2, 8'h02},
    '{1'b1, 4'ha, 8'hff, 8'h00}, '{1'b1, 4'h9, 8'h01, 8'h01},
    '{1'b1, 4'hc, 8'h55, 8'h55}, '{1'b1, 4'hb, 8'h33, 8'h00},
    '{1'b1, 4'h9, 8'h00, 8'h00}, '{1'b0, 4'hc, 8'h00, 8'h7f},
    '{1'b1, 4'h9, 8'h01, 8'h01}, '{1'b1, 4'hc, 8'h7f, 8'h7f},
    '{1'b1, 4'h9, 8'h00, 8'h00}};

  logic        sys_clk_in;
  logic        rstn_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [5:0]  paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        conv_start_out;
  logic        conv_chan_out;
  logic        conv_done_in;
  logic [7:0]  conv_data_in;
  logic [1:0]  diode_open_in;
  logic [1:0]  diode_short_in;
  logic        alert_out;
  logic        overtemp_shutdown_out;
  logic        mgmt_interrupt_out;
  logic        irq_out;
  logic [3:0]  done_cnt;
  logic [7:0]  rdv;
  int          n_fail;
  int          checks;
  int          n_starts;
  int          starts_snap;

  rdtm_monitor dut_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .conv_start_out(conv_start_out),
    .conv_chan_out(conv_chan_out), .conv_done_in(conv_done_in),
    .conv_data_in(conv_data_in), .diode_open_in(diode_open_in),
    .diode_short_in(diode_short_in), .alert_out(alert_out),
    .overtemp_shutdown_out(overtemp_shutdown_out),
    .mgmt_interrupt_out(mgmt_interrupt_out), .irq_out(irq_out));

  always #5 sys_clk_in = ~sys_clk_in;

  // Converter stand-in: answers each start after six cycles with -25.
  always @(posedge sys_clk_in) begin
    conv_done_in <= (done_cnt == 4'h1);
    if (done_cnt == 4'h1) conv_data_in <= 8'he7;
    if (conv_start_out === 1'b1) begin
      done_cnt <= 4'h6;
      n_starts <= n_starts + 1;
    end else if (done_cnt != 4'h0) begin
      done_cnt <= done_cnt - 4'h1;
    end
  end

  task chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  task chk1(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask : chk1

  // One APB transfer; an idle cycle follows so no strobe is driven twice.
  // The wait for ready has no limit of its own; the watchdog ends a hang.
  task apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
           output logic [7:0] rd);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= {idx, 2'b00};
    pwdata_in  <= {24'h000000, wd};
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out[7:0];
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : apb

  task wr(input logic [3:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, rdv);
  endtask : wr

  task rdc(input logic [3:0] idx, input logic [7:0] exp, input string name);
    apb(1'b0, idx, 8'h00, rdv);
    chk8(name, exp, rdv);
  endtask : rdc

  task run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      if (ROWS[i].wr) wr(ROWS[i].idx, ROWS[i].wd);
      rdc(ROWS[i].idx, ROWS[i].exp, $sformatf("reg %h", ROWS[i].idx));
    end
  endtask : run_rows

  // Outputs are registered, so a few edges pass before they are judged.
  task outs(input logic a, input logic o, input logic m, input logic q);
    repeat (3) @(posedge sys_clk_in);
    chk1("alert_out", a, alert_out);
    chk1("overtemp_shutdown_out", o, overtemp_shutdown_out);
    chk1("mgmt_interrupt_out", m, mgmt_interrupt_out);
    chk1("irq_out", q, irq_out);
  endtask : outs

  task do_reset;
    rstn_in <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    @(posedge sys_clk_in);
  endtask : do_reset

  task results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // Watchdog sized well above the roughly sixteen hundred cycles the tests need.
  initial begin
    #200000;
    n_fail++;
    results();
  end

  initial begin
    sys_clk_in = 1'b0;
    rstn_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 6'h00;
    pwdata_in = 32'h00000000;
    conv_done_in = 1'b0;
    conv_data_in = 8'h00;
    diode_open_in = 2'b00;
    diode_short_in = 2'b00;
    done_cnt = 4'h0;
    n_fail = 0;
    checks = 0;
    n_starts = 0;
    do_reset();
    outs(1'b0, 1'b0, 1'b0, 1'b0);
    run_rows(0, 11);
    run_rows(12, 26);
    // Channel 1 on, low limit +5, routes set; still in standby.
    wr(4'ha, 8'h11);
    wr(4'hd, 8'h05);
    wr(4'h2, 8'h01);
    wr(4'h4, 8'h02);
    repeat (300) @(posedge sys_clk_in);
    chk8("starts in standby", 8'h00, 8'(n_starts));
    rdc(4'hd, 8'h05, "low limit in standby");
    wr(4'h8, 8'h02);
    repeat (250) @(posedge sys_clk_in);
    wr(4'h8, 8'h03);
    repeat (30) @(posedge sys_clk_in);
    chk1("conversion ran", 1'b1, n_starts > 0);
    // Channel 2 is disabled, so only channel 1 may ever have been started.
    chk1("conv_chan_out", 1'b0, conv_chan_out);
    starts_snap = n_starts;
    // -25 is below +5 but not above 127 when compared as signed.
    rdc(4'hb, 8'he7, "reading ch1");
    rdc(4'ha, 8'h93, "cfg status ch1");
    rdc(4'h0, 8'h01, "event status");
    outs(1'b1, 1'b0, 1'b1, 1'b0);
    wr(4'h4, 8'h01);
    outs(1'b1, 1'b0, 1'b1, 1'b1);
    repeat (300) @(posedge sys_clk_in);
    chk8("starts after standby", 8'(starts_snap), 8'(n_starts));
    rdc(4'h0, 8'h01, "event held");
    wr(4'ha, 8'h11);
    rdc(4'ha, 8'h93, "zero write kept");
    wr(4'ha, 8'h93);
    rdc(4'ha, 8'h11, "one write cleared");
    rdc(4'h0, 8'h00, "event cleared");
    outs(1'b0, 1'b0, 1'b0, 1'b0);
    // Faults: channel 1 shorted low, channel 2 open.
    diode_short_in <= 2'b01;
    diode_open_in  <= 2'b10;
    wr(4'h9, 8'h01);
    wr(4'ha, 8'h31);
    wr(4'h9, 8'h00);
    wr(4'h8, 8'h00);
    repeat (400) @(posedge sys_clk_in);
    wr(4'h8, 8'h01);
    repeat (30) @(posedge sys_clk_in);
    rdc(4'hb, 8'h00, "short reading");
    rdc(4'ha, 8'h91, "short status");
    wr(4'h9, 8'h01);
    rdc(4'hb, 8'h7f, "open reading");
    rdc(4'ha, 8'hf1, "open status");
    wr(4'h9, 8'h00);
    rdc(4'h0, 8'h0c, "open events");
    outs(1'b1, 1'b1, 1'b0, 1'b0);
    // A second reset in mid-run brings back every default.
    do_reset();
    outs(1'b0, 1'b0, 1'b0, 1'b0);
    run_rows(0, 11);
    results();
  end
endmodule : remote_diode_temp_monitor_tb_top
